// ===== inc/phase_strobe_sync_map.vh
`ifndef PHASE_STROBE_SYNC_MAP_VH
`define PHASE_STROBE_SYNC_MAP_VH

// Register byte offsets on the AHB-Lite slave.
`define ADDR_CONFIG 8'h00
`define ADDR_SYNC 8'h04
`define ADDR_INCR 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_ACCUM 8'h10

// Configuration register fields.
`define CFG_TWO_CLK 0
`define CFG_SKIP 1
`define CFG_EDGE_INV 2
`define CFG_INTERP_LO 3
`define CFG_INTERP_HI 4
`define CFG_RESET 5'h02

// Sync control register fields.
`define SYNC_ACC_EN 0
`define SYNC_CM_EN 1
`define SYNC_SRC_LO 2
`define SYNC_SRC_HI 4
`define SYNC_NOW 5
`define SYNC_DIV 6
`define SYNC_RESET 5'h18

// Buffer sync source codes.
`define SRC_TXEN 3'h0
`define SRC_STROBE 3'h1
`define SRC_SOFT 3'h2
`define SRC_CHB15 3'h3
`define SRC_CHA15_ONCE 3'h4

// Interpolation codes.
`define INTERP_X2 2'h0
`define INTERP_X4 2'h1
`define INTERP_QUAD_LOW 2'h2
`define INTERP_X8 2'h3

// Timing and sizing counts.
`define NCO_LATENCY 13
`define STROBE_OUT_LATENCY 100
`define BUF_DEPTH 4
`define BUF_INIT_GAP 2

`endif

// ===== src/elastic_buffer.v
`timescale 1ns/1ps
`include "phase_strobe_sync_map.vh"

module elastic_buffer #(
   parameter WIDTH = 33,
   parameter DEPTH = `BUF_DEPTH,
   parameter PTR_W = 2
) (
   input wire hclk,
   input wire hresetn,
   input wire init,
   input wire wr_en,
   input wire [WIDTH-1:0] wr_data,
   input wire rd_en,
   output reg [WIDTH-1:0] rd_data
);

   localparam [PTR_W-1:0] INIT_GAP = `BUF_INIT_GAP;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [PTR_W-1:0] wr_ptr;
   reg [PTR_W-1:0] rd_ptr;

   // Storage words; stale contents are harmless because the pointers are re-spaced on init.
   always @(posedge hclk) begin
      if (wr_en) begin
         mem[wr_ptr] <= wr_data;
      end
   end

   // Pointers run free after init, so a drifting clock pair can overrun them (elastic behaviour).
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr <= {PTR_W{1'b0}};
         rd_ptr <= {PTR_W{1'b0}};
         rd_data <= {WIDTH{1'b0}};
      end else if (init) begin
         wr_ptr <= INIT_GAP; // R15
         rd_ptr <= {PTR_W{1'b0}}; // R15
      end else begin
         if (wr_en) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (rd_en) begin
            rd_data <= mem[rd_ptr];
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

endmodule

// ===== src/phase_strobe_sync_control.v
// Contract
// R1 - Single clock mode latches on rate clock output, edge chosen by lock_edge_invert.
// R2 - Rate clock output is the sample clock divided by interpolation setting.
// R3 - Single clock mode with buffer needs buffer initialization before data flows.
// R4 - Dual mode without buffer: source keeps input clock phase-aligned to sample clock.
// R5 - Dual mode with buffer latches on input clock and crosses via buffer.
// R6 - PLL mode latches on input clock and always bypasses the buffer.
// R7 - Oscillator, coarse mixer, buffer pointers and clock divider can be forced known.
// R8 - Phase strobe travels through the buffer path on the active input clock.
// R9 - Strobe clears the accumulator only while accumulator_reset_enable is set.
// R10 - Rising edge of buffered strobe causes synchronous accumulator clear.
// R11 - Clear lands 13 oscillator cycles after strobe edge leaves the buffer.
// R12 - Oscillator rate equals sample rate in X4, half in X2, quad_low, X8.
// R13 - Strobe to converter output latency is about 100 input clock cycles.
// R14 - Source tolerates a few input cycles of strobe arrival jitter with buffer.
// R15 - Initialization sets write pointer two entries ahead of read pointer.
// R16 - Sync sources are registered on write clock, then rising-edge detected.
// R17 - With clearing disabled the accumulator runs on and the strobe still passes.
// R18 - PLL supply strap is a static mode input: high PLL, low external.
`timescale 1ns/1ps
`include "phase_strobe_sync_map.vh"

module phase_strobe_sync_control #(
   parameter DATA_W = 16,
   parameter NCO_LATENCY = `NCO_LATENCY,
   parameter OUT_LATENCY = `STROBE_OUT_LATENCY
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire pll_supply_strap,
   input wire input_rate_clock,
   input wire [DATA_W-1:0] channel_a_input,
   input wire [DATA_W-1:0] channel_b_input,
   input wire phase_strobe,
   input wire tx_enable,
   output reg rate_clock_out,
   output reg [DATA_W-1:0] channel_a_out,
   output reg [DATA_W-1:0] channel_b_out,
   output reg strobe_buffered,
   output reg tx_enable_out,
   output reg [31:0] phase_accum,
   output reg accum_cleared,
   output reg [1:0] coarse_phase,
   output reg converter_strobe
);

   localparam WORD_W = 2 * DATA_W + 2;

   // Mode states, one-hot.
   localparam [2:0] MODE_SINGLE = 3'h1;
   localparam [2:0] MODE_DUAL = 3'h2;
   localparam [2:0] MODE_PLL = 3'h4;

   reg [4:0] config_reg;
   reg acc_reset_en;
   reg cm_sync_en;
   reg [2:0] sync_src;
   reg [31:0] phase_incr;
   reg soft_sync_req;
   reg div_sync_req;
   reg strap;
   reg [2:0] mode;
   reg ap_valid;
   reg ap_write;
   reg [7:0] ap_addr;
   reg [2:0] div_cnt;
   reg [2:0] next_div_cnt;
   reg rate_prev;
   reg in_clk_prev;
   reg nco_tog;
   reg [DATA_W-1:0] lat_a;
   reg [DATA_W-1:0] lat_b;
   reg lat_strobe;
   reg lat_txen;
   reg src_q;
   reg src_prev;
   reg once_armed;
   reg buf_ready;
   reg strobe_prev;
   reg [NCO_LATENCY-1:0] clr_pipe;
   reg [OUT_LATENCY-1:0] out_pipe;
   reg [15:0] clear_count;
   reg [31:0] read_word;
   reg src_sel;
   reg [2:0] div_max;

   wire two_clk = config_reg[`CFG_TWO_CLK];
   wire skip_bit = config_reg[`CFG_SKIP];
   wire edge_inv = config_reg[`CFG_EDGE_INV];
   wire [1:0] interp = config_reg[`CFG_INTERP_HI:`CFG_INTERP_LO];
   wire use_buffer = ~skip_bit & (mode != MODE_PLL); // R6
   wire lock_rise = rate_clock_out & ~rate_prev;
   wire lock_fall = ~rate_clock_out & rate_prev;
   wire in_rise = input_rate_clock & ~in_clk_prev;
   wire in_en = (mode == MODE_SINGLE) ? (edge_inv ? lock_fall : lock_rise) : in_rise; // R1
   wire out_en = (div_cnt == 3'h0);
   wire nco_en = (interp == `INTERP_X4) ? 1'b1 : nco_tog; // R12
   wire buf_init = in_en & src_q & ~src_prev; // R16
   wire [WORD_W-1:0] buf_rd;
   wire strobe_edge = strobe_buffered & ~strobe_prev; // R10
   wire do_clear = nco_en & clr_pipe[NCO_LATENCY-1] & acc_reset_en; // R9
   wire ap_take = hsel & htrans[1] & hready;

   // Strap is treated as static, so a single register stage is enough to hold the mode.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap <= 1'b0;
         mode <= MODE_SINGLE;
      end else begin
         strap <= pll_supply_strap; // R18
         if (strap) begin
            mode <= MODE_PLL; // R18
         end else if (two_clk) begin
            mode <= MODE_DUAL;
         end else begin
            mode <= MODE_SINGLE;
         end
      end
   end

   // AHB-Lite address phase capture; the slave never inserts wait states.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hready) begin
            ap_valid <= ap_take;
            ap_write <= hwrite;
            ap_addr <= haddr;
         end
      end
   end

   // Read word chosen from the address phase so it stands during the data phase.
   always @* begin
      read_word = 32'h00000000;
      if (haddr == `ADDR_CONFIG) begin
         read_word = {27'h0000000, config_reg};
      end else if (haddr == `ADDR_SYNC) begin
         read_word = {27'h0000000, sync_src, cm_sync_en, acc_reset_en};
      end else if (haddr == `ADDR_INCR) begin
         read_word = phase_incr;
      end else if (haddr == `ADDR_STATUS) begin
         read_word = {clear_count, 10'h000, use_buffer, buf_ready, mode, rate_clock_out};
      end else if (haddr == `ADDR_ACCUM) begin
         read_word = phase_accum;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (ap_take && !hwrite) begin
         hrdata <= read_word;
      end
   end

   // Register writes in the data phase; the soft sync request is sticky until its consumer takes it, the divider sync request lasts one cycle.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         config_reg <= `CFG_RESET;
         acc_reset_en <= 1'b0;
         cm_sync_en <= 1'b0;
         sync_src <= 3'h6;
         phase_incr <= 32'h00000000;
         soft_sync_req <= 1'b0;
         div_sync_req <= 1'b0;
      end else begin
         if (in_en) begin
            soft_sync_req <= 1'b0;
         end
         div_sync_req <= 1'b0;
         if (ap_valid && ap_write) begin
            if (ap_addr == `ADDR_CONFIG) begin
               config_reg <= hwdata[4:0];
            end else if (ap_addr == `ADDR_SYNC) begin
               acc_reset_en <= hwdata[`SYNC_ACC_EN];
               cm_sync_en <= hwdata[`SYNC_CM_EN];
               sync_src <= hwdata[`SYNC_SRC_HI:`SYNC_SRC_LO];
               if (hwdata[`SYNC_NOW]) begin
                  soft_sync_req <= 1'b1; // R7
               end
               div_sync_req <= hwdata[`SYNC_DIV]; // R7
            end else if (ap_addr == `ADDR_INCR) begin
               phase_incr <= hwdata;
            end
         end
      end
   end

   // Divider length per interpolation; quad_low shares the X4 length.
   always @* begin
      div_max = 3'h3;
      if (interp == `INTERP_X2) begin
         div_max = 3'h1;
      end else if (interp == `INTERP_X8) begin
         div_max = 3'h7;
      end
      if (div_sync_req) begin
         next_div_cnt = 3'h0; // R7
      end else if (mode == MODE_DUAL && !use_buffer && in_rise) begin
         next_div_cnt = 3'h0; // R4
      end else if (div_cnt >= div_max) begin
         next_div_cnt = 3'h0;
      end else begin
         next_div_cnt = div_cnt + 3'h1;
      end
   end

   // The rate clock is a register output fed from next_div_cnt, which keeps it glitch free and in step with div_cnt.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= 3'h0;
         rate_clock_out <= 1'b0;
         rate_prev <= 1'b0;
         in_clk_prev <= 1'b0;
         nco_tog <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         rate_clock_out <= (next_div_cnt <= (div_max >> 1)) && (mode != MODE_PLL); // R2
         rate_prev <= rate_clock_out;
         in_clk_prev <= input_rate_clock;
         nco_tog <= ~nco_tog; // R12
      end
   end

   // Input latch on the active mode's input clock edge.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lat_a <= {DATA_W{1'b0}};
         lat_b <= {DATA_W{1'b0}};
         lat_strobe <= 1'b0;
         lat_txen <= 1'b0;
      end else if (in_en) begin
         lat_a <= channel_a_input; // R5
         lat_b <= channel_b_input;
         lat_strobe <= phase_strobe; // R8
         lat_txen <= tx_enable;
      end
   end

   // Sync source selection; the da(15) source fires only once after each arming.
   always @* begin
      src_sel = 1'b0;
      if (sync_src == `SRC_TXEN) begin
         src_sel = tx_enable;
      end else if (sync_src == `SRC_STROBE) begin
         src_sel = phase_strobe;
      end else if (sync_src == `SRC_SOFT) begin
         src_sel = soft_sync_req;
      end else if (sync_src == `SRC_CHB15) begin
         src_sel = channel_b_input[DATA_W-1];
      end else if (sync_src == `SRC_CHA15_ONCE) begin
         src_sel = channel_a_input[DATA_W-1] & once_armed;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_q <= 1'b0;
         src_prev <= 1'b0;
         once_armed <= 1'b1;
         buf_ready <= 1'b0;
      end else begin
         if (in_en) begin
            src_q <= src_sel; // R16
            src_prev <= src_q; // R16
         end
         if (buf_init && sync_src == `SRC_CHA15_ONCE) begin
            once_armed <= 1'b0;
         end
         if (buf_init) begin
            buf_ready <= 1'b1; // R3
         end
      end
   end

   elastic_buffer #(
      .WIDTH(WORD_W),
      .DEPTH(`BUF_DEPTH),
      .PTR_W(2)
   ) u_buffer (
      .hclk(hclk),
      .hresetn(hresetn),
      .init(buf_init), // R7
      .wr_en(in_en),
      .wr_data({tx_enable, phase_strobe, channel_b_input, channel_a_input}),
      .rd_en(out_en),
      .rd_data(buf_rd)
   );

   // Output stage on the divided clock; an uninitialised buffer delivers zeros.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel_a_out <= {DATA_W{1'b0}};
         channel_b_out <= {DATA_W{1'b0}};
         strobe_buffered <= 1'b0;
         tx_enable_out <= 1'b0;
      end else if (out_en) begin
         if (!use_buffer) begin
            channel_a_out <= lat_a; // R6
            channel_b_out <= lat_b;
            strobe_buffered <= lat_strobe; // R8
            tx_enable_out <= lat_txen;
         end else if (buf_ready) begin
            channel_a_out <= buf_rd[DATA_W-1:0]; // R5
            channel_b_out <= buf_rd[2*DATA_W-1:DATA_W];
            strobe_buffered <= buf_rd[2*DATA_W]; // R14
            tx_enable_out <= buf_rd[2*DATA_W+1];
         end else begin
            channel_a_out <= {DATA_W{1'b0}}; // R3
            channel_b_out <= {DATA_W{1'b0}};
            strobe_buffered <= 1'b0;
            tx_enable_out <= 1'b0;
         end
      end
   end

   // Oscillator clear pipeline, one stage per oscillator tick.
   genvar i;
   generate
      for (i = 1; i < NCO_LATENCY; i = i + 1) begin : g_clr
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               clr_pipe[i] <= 1'b0;
            end else if (nco_en) begin
               clr_pipe[i] <= clr_pipe[i-1]; // R11
            end
         end
      end
   endgenerate

   // Accumulator keeps running when clearing is disabled; the pipeline still carries the edge.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clr_pipe[0] <= 1'b0;
         strobe_prev <= 1'b0;
         phase_accum <= 32'h00000000;
         accum_cleared <= 1'b0;
         clear_count <= 16'h0000;
      end else begin
         accum_cleared <= do_clear;
         if (nco_en) begin
            strobe_prev <= strobe_buffered;
            clr_pipe[0] <= strobe_edge; // R10
            if (do_clear) begin
               phase_accum <= 32'h00000000; // R10
               clear_count <= clear_count + 16'h0001;
            end else begin
               phase_accum <= phase_accum + phase_incr; // R17
            end
         end
      end
   end

   // Coarse mixer sequence is held at zero while its sync is on and the strobe is low.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         coarse_phase <= 2'h0;
      end else if (cm_sync_en && !strobe_buffered) begin
         coarse_phase <= 2'h0; // R7
      end else if (nco_en) begin
         coarse_phase <= coarse_phase + 2'h1;
      end
   end

   // Strobe delay to the converter output, counted in input clock events.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_pipe <= {OUT_LATENCY{1'b0}};
         converter_strobe <= 1'b0;
      end else if (in_en) begin
         out_pipe <= {out_pipe[OUT_LATENCY-2:0], lat_strobe}; // R13
         converter_strobe <= out_pipe[OUT_LATENCY-1]; // R13
      end
   end

endmodule

// ===== sim/phase_strobe_sync_properties.sv
`timescale 1ns/1ps
module sync_checker #(
   parameter NCO_LATENCY = 13,
   parameter OUT_LATENCY = 100
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire pll_supply_strap,
   input wire phase_strobe,
   input wire rate_clock_out,
   input wire strobe_buffered,
   input wire [31:0] phase_accum,
   input wire accum_cleared,
   input wire converter_strobe
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   reg ps_q;
   reg sb_q;
   reg [15:0] ps_age;
   reg [15:0] sb_age;
   wire delay_ok = sb_age >= NCO_LATENCY - 2 && sb_age <= 3 * NCO_LATENCY + 6;
   // Ages since the last strobe edges saturate, so a quiet run never wraps into a false match.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ps_q <= 1'b0;
         sb_q <= 1'b0;
         ps_age <= 16'hFFFF;
         sb_age <= 16'hFFFF;
      end else begin
         ps_q <= phase_strobe;
         sb_q <= strobe_buffered;
         ps_age <= (phase_strobe && !ps_q) ? 16'h0000 : ps_age + {15'h0000, ps_age != 16'hFFFF};
         sb_age <= (strobe_buffered && !sb_q) ? 16'h0000 : sb_age + {15'h0000, sb_age != 16'hFFFF};
      end
   end
   // A clear must leave a zero accumulator behind it, whichever edge raises the flag.
   property zeroed_p;
      accum_cleared |-> (phase_accum == 32'h00000000 || $past(phase_accum) == 32'h00000000);
   endproperty
   // Bus answers, PLL rate clock, strobe path and clear timing.
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   read_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   pll_clock_low_a: assert property (pll_supply_strap [*5] |-> !rate_clock_out)
      else $error("rate clock runs in pll mode");
   clear_pulse_a: assert property (accum_cleared |=> !accum_cleared)
      else $error("clear flag longer than one cycle");
   clear_value_a: assert property (zeroed_p)
      else $error("accumulator not zero at clear");
   clear_delay_a: assert property (accum_cleared |-> delay_ok)
      else $error("clear not at pipeline delay after strobe edge");
   strobe_path_a: assert property ($rose(strobe_buffered) |-> ps_age < 16'd64)
      else $error("buffered strobe without input strobe");
   delay_floor_a: assert property ($rose(converter_strobe) |-> ps_age >= OUT_LATENCY)
      else $error("converter strobe too early");
   // Main scenarios reached.
   cover property (accum_cleared);
   cover property ($rose(converter_strobe));
   cover property (pll_supply_strap && hsel && htrans[1]);
endmodule

bind phase_strobe_sync_control sync_checker #(
   .NCO_LATENCY(NCO_LATENCY),
   .OUT_LATENCY(OUT_LATENCY)
) checker_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .pll_supply_strap(pll_supply_strap), .phase_strobe(phase_strobe),
   .rate_clock_out(rate_clock_out), .strobe_buffered(strobe_buffered),
   .phase_accum(phase_accum), .accum_cleared(accum_cleared),
   .converter_strobe(converter_strobe)
);

// ===== sim/upstream_source.sv
`timescale 1ns/1ps
module upstream_source #(
   parameter HALF = 2,
   parameter DATA_W = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire use_input_clock,
   input wire rate_clock_out,
   input wire strobe_req,
   input wire txen_req,
   output reg input_rate_clock,
   output reg [DATA_W-1:0] channel_a_input,
   output reg [DATA_W-1:0] channel_b_input,
   output reg phase_strobe,
   output reg tx_enable
);
   reg [3:0] div;
   reg sel_q;
   reg [DATA_W-1:0] count;
   wire sel_clk = use_input_clock ? input_rate_clock : rate_clock_out;
   // The input clock is divided from hclk, so its edges stay aligned with the sample clock.
   // Words launch on the falling edge of the latch clock, leaving half a period either side.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div <= 4'h0;
         input_rate_clock <= 1'b0;
         sel_q <= 1'b0;
         count <= 1;
         channel_a_input <= 0;
         channel_b_input <= 0;
         phase_strobe <= 1'b0;
         tx_enable <= 1'b0;
      end else begin
         sel_q <= sel_clk;
         if (div == HALF - 1) begin
            div <= 4'h0;
            input_rate_clock <= ~input_rate_clock;
         end else begin
            div <= div + 4'h1;
         end
         if (sel_q && !sel_clk) begin
            count <= count + 1'b1;
            channel_a_input <= count;
            channel_b_input <= ~count;
            phase_strobe <= strobe_req;
            tx_enable <= txen_req;
         end
      end
   end
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
`include "phase_strobe_sync_map.vh"
module tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic pll_supply_strap = 1'b0;
   logic use_input_clock = 1'b0;
   logic strobe_req = 1'b0;
   logic txen_req = 1'b0;
   logic rc_q = 1'b0;
   logic [31:0] q;
   wire [31:0] hrdata, phase_accum;
   wire [15:0] channel_a_input, channel_b_input, channel_a_out, channel_b_out;
   wire [1:0] coarse_phase;
   wire hreadyout, hresp, rate_clock_out, strobe_buffered, tx_enable_out, accum_cleared;
   wire converter_strobe, input_rate_clock, phase_strobe, tx_enable;
   int n_fail = 0;
   int checks = 0;
   int len[4] = '{2, 4, 4, 8};
   int i, k, n, t_sb, t_clr, t_cs;

   phase_strobe_sync_control DUT (.hsize(3'h2), .hready(hreadyout), .*);
   upstream_source far_end (.*);

   // Half period of 12.5 ns gives the 40 MHz bus clock.
   always #12.5 hclk = ~hclk;

   // The whole run needs about 1500 cycles, so this limit only trips on a hang.
   initial begin
      #(25 * 20000);
      n_fail++;
      complete_run;
   end

   task complete_run;
      if (n_fail == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One single transfer; the address holds until hready is seen high, then the data phase.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   // Both channels travel as one word, so b must stay the bitwise inverse of a.
   task pair_check;
      check("pair", {16'h0, channel_b_out}, {16'h0, ~channel_a_out});
      check("flow", 32'(channel_a_out != 16'h0), 32'h1);
   endtask

   // Raises the strobe for 17 cycles and times its arrival at each output.
   task pulse;
      t_sb = -1;
      t_clr = -1;
      t_cs = -1;
      // A strobe still standing from the last pulse would end the timing loop at once.
      for (k = 0; k < 200 && converter_strobe !== 1'b0; k++) @(posedge hclk);
      strobe_req <= 1'b1;
      for (k = 0; k < 1500 && t_cs < 0; k++) begin
         @(posedge hclk);
         if (k == 16) strobe_req <= 1'b0;
         if (t_sb < 0 && strobe_buffered === 1'b1) t_sb = k;
         if (t_clr < 0 && accum_cleared === 1'b1) t_clr = k;
         if (converter_strobe === 1'b1) t_cs = k;
      end
   endtask

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`ADDR_CONFIG);
      check("config reset", q, {27'h0, `CFG_RESET});
      rd(8'h20);
      check("unmapped", q, 32'h0);
      rd(`ADDR_STATUS);
      check("mode single", {29'h0, q[3:1]}, 32'h1);
      wr(`ADDR_INCR, 32'h1);
      // Divider length and oscillator rate for every interpolation code.
      for (i = 0; i < 4; i++) begin
         wr(`ADDR_CONFIG, 32'h2 | 32'(i << 3));
         repeat (20) @(posedge hclk);
         q = phase_accum;
         rc_q = rate_clock_out;
         n = 0;
         for (k = 0; k < 64; k++) begin
            @(posedge hclk);
            n += (rate_clock_out === 1'b1 && rc_q === 1'b0);
            rc_q = rate_clock_out;
         end
         check("rate clock edges", 32'(n), 32'(64 / len[i]));
         check("accum step", phase_accum - q, (i == 1) ? 32'd64 : 32'd32);
      end
      // Single clock mode latches on either edge of the rate clock.
      for (i = 0; i < 2; i++) begin
         wr(`ADDR_CONFIG, 32'h0A | 32'(i << 2));
         repeat (40) @(posedge hclk);
         pair_check;
      end
      // The buffer holds words back until a soft sync sets its pointers.
      wr(`ADDR_CONFIG, 32'h08);
      wr(`ADDR_SYNC, 32'h08);
      repeat (40) @(posedge hclk);
      check("no init", {16'h0, channel_a_out}, 32'h0);
      rd(`ADDR_STATUS);
      check("in use", {30'h0, q[5:4]}, 32'h2);
      wr(`ADDR_SYNC, 32'h28);
      repeat (40) @(posedge hclk);
      rd(`ADDR_STATUS);
      check("init", {30'h0, q[5:4]}, 32'h3);
      pair_check;
      // A second reset leaves the buffer unset for the dual clock run.
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      use_input_clock <= 1'b1;
      wr(`ADDR_CONFIG, 32'h0D);
      wr(`ADDR_SYNC, 32'h00);
      repeat (40) @(posedge hclk);
      check("dual wait", {16'h0, channel_a_out}, 32'h0);
      txen_req <= 1'b1;
      repeat (40) @(posedge hclk);
      rd(`ADDR_STATUS);
      check("dual init", {27'h0, q[5:1]}, 32'h1A);
      pair_check;
      check("txen pass", {31'h0, tx_enable_out}, 32'h1);
      // Strobe clears the accumulator, then passes unheeded once clearing is off.
      wr(`ADDR_CONFIG, 32'h0B);
      wr(`ADDR_INCR, 32'h1);
      wr(`ADDR_SYNC, 32'h19);
      repeat (20) @(posedge hclk);
      pulse;
      check("strobe out", 32'(t_sb >= 0), 32'h1);
      check("clear delay", 32'((t_clr - t_sb) inside {[12:17]}), 32'h1);
      check("converter delay", 32'(t_cs inside {[396:424]}), 32'h1);
      rd(`ADDR_STATUS);
      check("clear count", {16'h0, q[31:16]}, 32'h1);
      wr(`ADDR_SYNC, 32'h18);
      pulse;
      check("strobe kept", 32'(t_sb >= 0), 32'h1);
      check("no clear", 32'(t_clr), 32'hFFFFFFFF);
      // The strap forces the bypass and stops the rate clock.
      pll_supply_strap <= 1'b1;
      wr(`ADDR_CONFIG, 32'h08);
      repeat (40) @(posedge hclk);
      rd(`ADDR_STATUS);
      check("pll mode", {27'h0, q[5], q[3:0]}, 32'h08);
      pair_check;
      // The coarse counter is held at zero while its sync is on and the strobe is low.
      wr(`ADDR_SYNC, 32'h02);
      repeat (4) @(posedge hclk);
      check("coarse held", {30'h0, coarse_phase}, 32'h0);
      wr(`ADDR_SYNC, 32'h00);
      repeat (3) @(posedge hclk);
      q = coarse_phase;
      @(posedge hclk);
      check("coarse run", {30'h0, coarse_phase}, {30'h0, q[1:0] + 2'h1});
      complete_run;
   end
endmodule
